// [osctc_top.sv]
// Oscillator trim registers and clock multiplier control behind an APB slave
`include "osctc_regs.svh"
module osctc_top
	import osctc_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst_b,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [ADDR_W-1:0]          paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [`OSCTC_COARSE_W-1:0] i_factory_coarse,
	input  wire logic [`OSCTC_FINE_W-1:0]   i_factory_fine,
	input  wire logic                       i_pll_lock,
	input  wire logic                       i_pll_in_clk,
	input  wire logic                       i_pll_in_below_min,
	input  wire logic [1:0]                 i_system_clock_source_select,
	output logic      [`OSCTC_COARSE_W-1:0] o_coarse_trim,
	output logic      [`OSCTC_FINE_W-1:0]   o_fine_trim,
	output logic                            o_pll_enable,
	output logic                            o_pll_init_start,
	output logic                            o_pll_ready,
	output logic      [1:0]                 o_pll_input_select,
	output logic                            o_pll_in_external,
	output logic                            o_pll_in_halved,
	output logic      [1:0]                 o_scale_num,
	output logic      [2:0]                 o_scale_den,
	output logic                            o_system_clock_from_pll,
	output logic                            o_burst_pulse
);

	// Address decode needs room for the highest word index
	if (ADDR_W < 10 || ADDR_W > 32)
	begin : g_addr_w_check
		$error("ADDR_W must be 10 to 32");
	end

	logic [`OSCTC_COARSE_W-1:0] coarse_reg;
	logic [`OSCTC_FINE_W-1:0]   fine_reg;
	logic                       trim_loaded_reg;
	logic                       ctrl_en_reg;
	logic                       init_reg;
	logic [2:0]                 scale_reg;
	logic [1:0]                 sel_reg;
	osctc_state_t               state_reg;
	osctc_state_t               state_next;
	osctc_ratio_t               ratio_reg;
	osctc_ratio_t               ratio_next;
	logic [31:0]                prdata_reg;
	logic                       init_start_reg;
	logic                       system_clock_pll_reg;
	logic                       in_prev_reg;
	logic [3:0]                 burst_cnt_reg;
	logic                       burst_pulse_reg;
	logic [ADDR_W-3:0]          word_idx;
	logic                       hit_ctrl;
	logic                       hit_fine;
	logic                       hit_coarse;
	logic                       aligned;
	logic                       wr_acc;
	logic                       setup;
	logic                       init_write;
	logic                       burst_start;
	logic [7:0]                 wbyte;
	logic [7:0]                 ctrl_rd;
	logic [31:0]                rd_next;

	assign word_idx   = paddr[ADDR_W-1:2];
	assign aligned    = (paddr[1:0] == 2'h0);
	assign hit_ctrl   = aligned && (word_idx == (ADDR_W-2)'(`OSCTC_IDX_PLL_CONTROL));
	assign hit_fine   = aligned && (word_idx == (ADDR_W-2)'(`OSCTC_IDX_FINE_TRIM));
	assign hit_coarse = aligned && (word_idx == (ADDR_W-2)'(`OSCTC_IDX_COARSE_TRIM));
	assign setup      = psel && !penable;
	assign wr_acc     = psel && penable && pwrite;
	assign wbyte      = pwdata[7:0];
	// Zero wait states; unmapped or unaligned words answer with an error
	assign pready     = 1'b1;
	assign pslverr    = psel && penable && !(hit_ctrl || hit_fine || hit_coarse);
	assign prdata     = prdata_reg;

	// Ready bit is the lock state, never the written value
	assign ctrl_rd = {ctrl_en_reg, init_reg, (state_reg == OSCTC_READY), scale_reg, sel_reg};

	always_comb
	begin
		rd_next = 32'h0000_0000;
		if (hit_ctrl)
			rd_next = {24'h00_0000, ctrl_rd};
		else if (hit_fine)
			rd_next = {26'h000_0000, fine_reg};
		else if (hit_coarse)
			rd_next = {25'h000_0000, coarse_reg};
	end

	// Read data is sampled in the setup phase, so a read sees state before its own access edge
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			prdata_reg <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata_reg <= rd_next;
	end

	// Factory values are caught on the first edge after release, not under reset
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			coarse_reg      <= 7'h00;
			fine_reg        <= 6'h00;
			trim_loaded_reg <= 1'b0;
		end
		else if (!trim_loaded_reg)
		begin
			coarse_reg      <= i_factory_coarse;
			fine_reg        <= i_factory_fine;
			trim_loaded_reg <= 1'b1;
		end
		else if (wr_acc)
		begin
			if (hit_coarse)
				coarse_reg <= wbyte[`OSCTC_COARSE_W-1:0];
			if (hit_fine)
				fine_reg <= wbyte[`OSCTC_FINE_W-1:0];
		end
	end

	assign init_write = wr_acc && hit_ctrl && wbyte[`OSCTC_EN_BIT] && ctrl_en_reg && wbyte[`OSCTC_INIT_BIT];

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			ctrl_en_reg <= 1'b0;
			init_reg    <= 1'b0;
			scale_reg   <= 3'h0;
			sel_reg     <= 2'h0;
		end
		else if (wr_acc && hit_ctrl)
		begin
			ctrl_en_reg <= wbyte[`OSCTC_EN_BIT];
			// Init only sticks once enable was already set
			init_reg    <= init_write;
			scale_reg   <= wbyte[`OSCTC_SCALE_HI:`OSCTC_SCALE_LO];
			sel_reg     <= wbyte[`OSCTC_SEL_HI:`OSCTC_SEL_LO];
		end
	end

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			OSCTC_OFF:
				if (ctrl_en_reg)
					state_next = OSCTC_ENABLED;
			OSCTC_ENABLED:
				if (init_start_reg)
					state_next = OSCTC_LOCKING;
			OSCTC_LOCKING:
				if (i_pll_lock)
					state_next = OSCTC_READY;
			OSCTC_READY:
				if (!i_pll_lock || init_start_reg)
					state_next = OSCTC_LOCKING;
		endcase
		// Disabling write drops ready at its own edge, so no read sees ready without enable
		if (!ctrl_en_reg || (wr_acc && hit_ctrl && !wbyte[`OSCTC_EN_BIT]))
			state_next = OSCTC_OFF;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg      <= OSCTC_OFF;
			init_start_reg <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			init_start_reg <= init_write;
		end
	end

	always_comb
	begin
		ratio_next = '{num: 2'h2, den: scale_reg};
		if (scale_reg <= `OSCTC_SCALE_UNITY_MAX)
			ratio_next = '{num: 2'h1, den: 3'h1};
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			ratio_reg      <= '{num: 2'h1, den: 3'h1};
			system_clock_pll_reg <= 1'b0;
		end
		else
		begin
			ratio_reg      <= ratio_next;
			system_clock_pll_reg <= (i_system_clock_source_select == `OSCTC_CLKSRC_PLL);
		end
	end

	// Slow input: one burst of four pulses per rising edge, retrigger ignored mid-burst
	assign burst_start = ctrl_en_reg && i_pll_in_below_min && i_pll_in_clk && !in_prev_reg && (burst_cnt_reg == 4'h0);

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			in_prev_reg     <= 1'b0;
			burst_cnt_reg   <= 4'h0;
			burst_pulse_reg <= 1'b0;
		end
		else
		begin
			in_prev_reg     <= i_pll_in_clk;
			burst_pulse_reg <= (burst_cnt_reg != 4'h0) && burst_cnt_reg[0];
			if (!ctrl_en_reg)
				burst_cnt_reg <= 4'h0;
			else if (burst_start)
				burst_cnt_reg <= `OSCTC_BURST_LOAD;
			else if (burst_cnt_reg != 4'h0)
				burst_cnt_reg <= burst_cnt_reg - 4'h1;
		end
	end

	assign o_coarse_trim      = coarse_reg;
	assign o_fine_trim        = fine_reg;
	assign o_pll_enable       = ctrl_en_reg;
	assign o_pll_init_start   = init_start_reg;
	assign o_pll_ready        = (state_reg == OSCTC_READY);
	assign o_pll_input_select = sel_reg;
	assign o_pll_in_external  = (sel_reg != 2'h0);
	assign o_pll_in_halved    = (sel_reg != `OSCTC_SEL_EXT_DIRECT);
	assign o_scale_num        = ratio_reg.num;
	assign o_scale_den        = ratio_reg.den;
	assign o_system_clock_from_pll  = system_clock_pll_reg;
	assign o_burst_pulse      = burst_pulse_reg;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);

	a_coarse_write: assert property (wr_acc && hit_coarse && trim_loaded_reg |=> o_coarse_trim == $past(pwdata[6:0]))
		else $error("coarse trim not written");
	a_coarse_top_zero: assert property (setup && !pwrite && hit_coarse |=> prdata[31:7] == 25'h0)
		else $error("coarse trim upper bits not zero");
	a_trim_factory: assert property ($rose(trim_loaded_reg) |-> o_coarse_trim == $past(i_factory_coarse) && o_fine_trim == $past(i_factory_fine))
		else $error("factory trim not loaded");
	a_fine_top_zero: assert property (setup && !pwrite && hit_fine |=> prdata[31:6] == 26'h0 && prdata[5:0] == $past(fine_reg))
		else $error("fine trim readback wrong");
	a_scale_map: assert property (wr_acc && hit_ctrl && pwdata[4:2] == 3'h7 |=> ##1 o_scale_num == 2'h2 && o_scale_den == 3'h7)
		else $error("scale 2/7 not applied");
	a_scale_unity: assert property (wr_acc && hit_ctrl && pwdata[4:2] <= 3'h2 |=> ##1 o_scale_num == 2'h1 && o_scale_den == 3'h1)
		else $error("unity scale not applied");
	a_input_path: assert property (wr_acc && hit_ctrl && pwdata[1:0] == 2'h1 |=> o_pll_in_external && o_pll_in_halved)
		else $error("external halved path wrong");
	a_ready_lock: assert property ($rose(o_pll_ready) |-> $past(i_pll_lock) && $past(ctrl_en_reg))
		else $error("ready without lock");
	a_fresh_init: assert property ($rose(ctrl_en_reg) |-> !init_reg && !o_pll_ready)
		else $error("init set on fresh enable");
	a_disable_drop: assert property (wr_acc && hit_ctrl && pwdata[7] == 1'b0 |=> ##1 !o_pll_ready && !init_reg)
		else $error("ready kept after disable");
	a_ctrl_readback: assert property (wr_acc && hit_ctrl && pwdata[7:0] == 8'h00 |=> ctrl_rd == `OSCTC_CTRL_RESET)
		else $error("control not cleared");
	a_burst_four: assert property (disable iff (!i_rst_b || !ctrl_en_reg) burst_start |-> ##3 o_burst_pulse ##1 !o_burst_pulse
		##1 o_burst_pulse ##1 !o_burst_pulse ##1 o_burst_pulse ##1 !o_burst_pulse ##1 o_burst_pulse ##1 !o_burst_pulse)
		else $error("burst not four pulses");
	a_system_clock_code: assert property (i_system_clock_source_select == 2'h3 |=> !o_system_clock_from_pll)
		else $error("reserved source picked multiplier");

	c_ready: cover property ($rose(o_pll_ready));
	c_burst: cover property (burst_start);
	c_init: cover property (o_pll_init_start);
	c_err: cover property (pslverr);

endmodule

// [osctc_regs.svh]
// Register indices, field positions, reset values and counts of the trim and multiplier control
`ifndef OSCTC_REGS_SVH
`define OSCTC_REGS_SVH
// Printed offsets are word indices; byte address is four times the index
`define OSCTC_IDX_PLL_CONTROL 8'h97
`define OSCTC_IDX_FINE_TRIM   8'h9E
`define OSCTC_IDX_COARSE_TRIM 8'hA2
`define OSCTC_EN_BIT          7
`define OSCTC_INIT_BIT        6
`define OSCTC_READY_BIT       5
`define OSCTC_SCALE_HI        4
`define OSCTC_SCALE_LO        2
`define OSCTC_SEL_HI          1
`define OSCTC_SEL_LO          0
`define OSCTC_COARSE_W        7
`define OSCTC_FINE_W          6
`define OSCTC_CTRL_RESET      8'h00
`define OSCTC_SEL_EXT_DIRECT  2'h2
`define OSCTC_CLKSRC_PLL      2'h2
`define OSCTC_SCALE_UNITY_MAX 3'h2
`define OSCTC_BURST_PULSES    4
`define OSCTC_BURST_LOAD      4'h8
`endif

// [osctc_pkg.sv]
// Types shared by the oscillator trim and clock multiplier control
package osctc_pkg;
	typedef enum logic [1:0] {OSCTC_OFF, OSCTC_ENABLED, OSCTC_LOCKING, OSCTC_READY} osctc_state_t;
	typedef struct packed
	{
		logic [1:0] num;
		logic [2:0] den;
	} osctc_ratio_t;
endpackage

// [osctc_pll_model.sv]
// Behavioural analog multiplier core that reports lock after a settling delay
module osctc_pll_model
#(
	parameter int LOCK_DLY = 12
)
(
	input  wire logic i_ref_clk,
	input  wire logic i_rst_b,
	input  wire logic i_pll_enable,
	input  wire logic i_pll_init_start,
	output logic      o_pll_lock
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// Lock only after a full settling time; losing enable loses lock at the next clock edge
	always @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b || !i_pll_enable)
		begin
			cnt <= 0;
			o_pll_lock <= 1'b0;
		end
		else if (i_pll_init_start)
		begin
			cnt <= LOCK_DLY;
			o_pll_lock <= 1'b0;
		end
		else if (cnt > 0)
		begin
			cnt <= cnt - 1;
			o_pll_lock <= (cnt == 1);
		end
	end
endmodule

// [tb_osctc_top.sv]
// Register-level testbench for the trim and multiplier control
`include "osctc_regs.svh"
module tb_osctc_top
	import osctc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] A_CTL = 12'(4 * `OSCTC_IDX_PLL_CONTROL);
	localparam logic [11:0] A_FIN = 12'(4 * `OSCTC_IDX_FINE_TRIM);
	localparam logic [11:0] A_CRS = 12'(4 * `OSCTC_IDX_COARSE_TRIM);
	logic        i_ref_clk = 1'b0, i_rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, lock, en, init_go, rdy, ext, halved, from_pll, burst;
	logic        in_clk = 1'b0, below = 1'b0;
	logic [1:0]  src = 2'h0, num, sel;
	logic [5:0]  fine;
	logic [2:0]  den;
	logic [6:0]  coarse;
	int          n_fail = 0, num_checks = 0, cyc = 0, n;

	osctc_top dut (.i_ref_clk, .i_rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .i_factory_coarse(7'h55), .i_factory_fine(6'h2A), .i_pll_lock(lock),
		.i_pll_in_clk(in_clk), .i_pll_in_below_min(below), .i_system_clock_source_select(src),
		.o_coarse_trim(coarse), .o_fine_trim(fine), .o_pll_enable(en), .o_pll_init_start(init_go),
		.o_pll_ready(rdy), .o_pll_input_select(sel), .o_pll_in_external(ext), .o_pll_in_halved(halved),
		.o_scale_num(num), .o_scale_den(den), .o_system_clock_from_pll(from_pll), .o_burst_pulse(burst));
	osctc_pll_model core (.i_ref_clk, .i_rst_b, .i_pll_enable(en), .i_pll_init_start(init_go),
		.o_pll_lock(lock));

	always #50 i_ref_clk = ~i_ref_clk;

	// Whole run needs well under a thousand cycles
	always @(posedge i_ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	task print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge i_ref_clk);
		penable <= 1'b1;
		do
			@(posedge i_ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask

	initial
	begin
		repeat (20) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		rdc(A_CRS, 32'h55);
		rdc(A_FIN, 32'h2A);
		rdc(A_CTL, 32'h00);
		apb(1'b1, A_CRS, 8'hFF);
		rdc(A_CRS, 32'h7F);
		chk(32'(coarse), 32'h7F);
		apb(1'b1, A_FIN, 8'hFF);
		rdc(A_FIN, 32'h3F);
		chk(32'(fine), 32'h3F);
		apb(1'b0, 12'h004, 8'h00);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, A_CTL, 8'h20);
		rdc(A_CTL, 32'h00);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, A_CTL, {3'h0, 3'(i), 2'(i)});
			repeat (2) @(posedge i_ref_clk);
			chk({27'h0, num, den}, (i < 3) ? 32'h9 : {27'h0, 2'h2, 3'(i)});
			chk({30'h0, ext, halved}, {30'h0, 2'(i) != 2'h0, 2'(i) != 2'h2});
			chk({30'h0, sel}, {30'h0, 2'(i)});
		end
		// Init in the same write that first enables is refused
		apb(1'b1, A_CTL, 8'hC0);
		rdc(A_CTL, 32'h80);
		apb(1'b1, A_CTL, 8'h00);
		// External input halved, scaled 2/3: aims at the recommended output band
		apb(1'b1, A_CTL, 8'h0D);
		apb(1'b1, A_CTL, 8'h8D);
		rdc(A_CTL, 32'h8D);
		chk(32'(en), 32'h1);
		// More than five microseconds at this clock rate; external source already running
		repeat (51) @(posedge i_ref_clk);
		apb(1'b1, A_CTL, 8'hCD);
		@(negedge i_ref_clk);
		chk(32'(init_go), 32'h1);
		rdc(A_CTL, 32'hCD);
		for (int k = 0; k < 40 && rd[5] !== 1'b1; k++)
			apb(1'b0, A_CTL, 8'h00);
		chk(rd, 32'hED);
		chk(32'(rdy), 32'h1);
		apb(1'b1, A_CTL, 8'h8D);
		rdc(A_CTL, 32'hAD);
		below <= 1'b1;
		in_clk <= 1'b1;
		n = 0;
		// Sampled between edges, where each pulse has settled
		repeat (14)
		begin
			@(negedge i_ref_clk);
			n += int'(burst);
		end
		chk(32'(n), 32'h4);
		@(posedge i_ref_clk);
		in_clk <= 1'b0;
		below <= 1'b0;
		apb(1'b1, A_CTL, 8'h00);
		repeat (2) @(posedge i_ref_clk);
		chk(32'(rdy), 32'h0);
		rdc(A_CTL, 32'h00);
		src <= 2'h2;
		repeat (2) @(posedge i_ref_clk);
		chk(32'(from_pll), 32'h1);
		src <= 2'h3;
		repeat (2) @(posedge i_ref_clk);
		chk(32'(from_pll), 32'h0);
		print_verdict();
	end
endmodule
